// ==== hw/tdc_pkg.sv ====
/*
  Constants for the tone, dial-pulse and cadence control block.
  Assumes a 25 MHz system clock and 32-bit Avalon-MM register access.
*/
`default_nettype none
package tdc_pkg;
  // =====================================
  // Register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_CTL_WR = 8'hDE;
  localparam logic [7:0] IDX_CTL_RD = 8'hDF;
  localparam logic [7:0] IDX_CAD_WR = 8'hE0;
  localparam logic [7:0] IDX_CAD_RD = 8'hE1;
  localparam logic [7:0] IDX_STAT = 8'h4D;
  localparam logic [7:0] IDX_MASK = 8'h6C;
  // =====================================
  // Control byte fields
  localparam int B_CAD = 7;
  localparam int B_OS = 6;
  localparam int B_DP = 5;
  localparam int B_TB = 1;
  localparam int B_TA = 0;
  localparam logic [7:0] CTL_WMASK = 8'hE3;
  localparam logic [7:0] CTL_GENS = 8'h23;
  localparam logic [7:0] CTL_RST = 8'h00;
  // =====================================
  // Cadence timer fields
  localparam int TW = 11;
  localparam int ON_LSB = 16;
  localparam int OFF_LSB = 0;
  localparam logic [TW-1:0] ON_RST = 11'h190;
  localparam logic [TW-1:0] OFF_RST = 11'h320;
  localparam logic [TW-1:0] T_ZERO = 11'h000;
  localparam logic [TW-1:0] T_ONE = 11'h001;
  // Status and mask
  localparam int B_DONE = 0;
  localparam logic MASK_RST = 1'b1;
  // =====================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int STEP_MS = 5;
  localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  typedef enum logic [1:0] {S_IDLE, S_ON, S_OFF, S_HOLD} tdc_state_t;
endpackage : tdc_pkg
`default_nettype wire

// ==== hw/tdc_cadence_ctl.sv ====
/*
  Tone A/B and dial-pulse enable control with shared cadence timer,
  done flag, mask and interrupt, behind an Avalon-MM slave.
  Assumes a synchronous master on clk; tone datapath lives elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
module tdc_cadence_ctl #(
  parameter int STEP_CYCLES = tdc_pkg::STEP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic toneAEnable,
  output logic toneBEnable,
  output logic generalIoPinOne,
  output logic irq
);
  // =====================================
  // Bus decode
  logic [7:0] idx;
  logic req;
  logic ack;
  logic ctlWr;
  logic cadWr;
  logic statWr;
  logic maskWr;
  assign idx = address[9:2];
  assign req = read | write;
  assign ack = req & ~waitrequest;
  assign ctlWr = ack & write & (idx == tdc_pkg::IDX_CTL_WR);
  assign cadWr = ack & write & (idx == tdc_pkg::IDX_CAD_WR);
  assign statWr = ack & write & (idx == tdc_pkg::IDX_STAT);
  assign maskWr = ack & write & (idx == tdc_pkg::IDX_MASK);

  logic [7:0] ctl;
  logic [tdc_pkg::TW-1:0] onTime;
  logic [tdc_pkg::TW-1:0] offTime;
  logic doneFlag;
  logic doneMask;
  tdc_pkg::tdc_state_t st;
  logic [tdc_pkg::TW-1:0] cnt;
  logic [31:0] pre;
  logic tick;
  logic onEnd;
  logic offEnd;
  logic lastStep;

  // One wait cycle per access keeps read data from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else if (req && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  function automatic logic [7:0] ctl_view(input logic [7:0] c,
                                          input tdc_pkg::tdc_state_t s);
    ctl_view = (s == tdc_pkg::S_OFF) ? (c & ~tdc_pkg::CTL_GENS) : c;
  endfunction : ctl_view

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= 32'h0000_0000;
      case (idx)
        tdc_pkg::IDX_CTL_RD, tdc_pkg::IDX_CTL_WR: begin
          readdata[7:0] <= ctl_view(ctl, st);
        end
        tdc_pkg::IDX_CAD_RD, tdc_pkg::IDX_CAD_WR: begin
          readdata[tdc_pkg::ON_LSB +: tdc_pkg::TW] <= onTime;
          readdata[tdc_pkg::OFF_LSB +: tdc_pkg::TW] <= offTime;
        end
        tdc_pkg::IDX_STAT: begin
          readdata[tdc_pkg::B_DONE] <= doneFlag;
        end
        tdc_pkg::IDX_MASK: begin
          readdata[tdc_pkg::B_DONE] <= doneMask;
        end
        default: begin
          readdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // =====================================
  // Registers
  // Reserved bits are dropped, so they always read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl <= tdc_pkg::CTL_RST;
    end else if (ctlWr) begin
      ctl <= writedata[7:0] & tdc_pkg::CTL_WMASK;
    end else if (offEnd && ctl[tdc_pkg::B_OS]) begin
      ctl <= tdc_pkg::CTL_RST;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      onTime <= tdc_pkg::ON_RST;
      offTime <= tdc_pkg::OFF_RST;
    end else if (cadWr) begin
      onTime <= writedata[tdc_pkg::ON_LSB +: tdc_pkg::TW];
      offTime <= writedata[tdc_pkg::OFF_LSB +: tdc_pkg::TW];
    end
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      doneFlag <= 1'b0;
    end else begin
      doneFlag <= onEnd | (doneFlag & ~(statWr & writedata[tdc_pkg::B_DONE]));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      doneMask <= tdc_pkg::MASK_RST;
    end else if (maskWr) begin
      doneMask <= writedata[tdc_pkg::B_DONE];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= doneFlag & ~doneMask;
    end
  end

  // =====================================
  // 5 ms step divider, realigned on restart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre <= 32'h0000_0000;
    end else if (ctlWr || tick) begin
      pre <= 32'h0000_0000;
    end else begin
      pre <= pre + 32'h0000_0001;
    end
  end
  assign tick = (pre == 32'(STEP_CYCLES - 1));
  // A zero time ends at the first step
  assign lastStep = tick && (cnt <= tdc_pkg::T_ONE);
  assign onEnd = !ctlWr && (st == tdc_pkg::S_ON) && lastStep;
  assign offEnd = !ctlWr && (st == tdc_pkg::S_OFF) && lastStep;

  // =====================================
  // Cadence sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= tdc_pkg::S_IDLE;
      cnt <= tdc_pkg::T_ZERO;
    end else if (ctlWr) begin
      if (writedata[tdc_pkg::B_CAD]) begin
        st <= tdc_pkg::S_ON;
        cnt <= onTime;
      end else begin
        st <= tdc_pkg::S_IDLE;
        cnt <= tdc_pkg::T_ZERO;
      end
    end else begin
      case (st)
        tdc_pkg::S_ON: begin
          if (onEnd) begin
            if (!ctl[tdc_pkg::B_OS] && offTime == tdc_pkg::T_ZERO) begin
              st <= tdc_pkg::S_HOLD;
            end else begin
              st <= tdc_pkg::S_OFF;
              cnt <= offTime;
            end
          end else if (tick) begin
            cnt <= cnt - tdc_pkg::T_ONE;
          end
        end
        tdc_pkg::S_OFF: begin
          if (offEnd) begin
            if (ctl[tdc_pkg::B_OS]) begin
              st <= tdc_pkg::S_IDLE;
            end else begin
              st <= tdc_pkg::S_ON;
              cnt <= onTime;
            end
          end else if (tick) begin
            cnt <= cnt - tdc_pkg::T_ONE;
          end
        end
        default: begin
          cnt <= tdc_pkg::T_ZERO;
        end
      endcase
    end
  end

  // =====================================
  // Function gating
  logic active;
  assign active = ctl[tdc_pkg::B_CAD] ? (st == tdc_pkg::S_ON || st == tdc_pkg::S_HOLD)
                                      : 1'b1;
  // Pin one high means relay current flows; pulsing drops it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      toneAEnable <= 1'b0;
      toneBEnable <= 1'b0;
      generalIoPinOne <= 1'b1;
    end else begin
      toneAEnable <= ctl[tdc_pkg::B_TA] & active;
      toneBEnable <= ctl[tdc_pkg::B_TB] & active;
      generalIoPinOne <= ~(ctl[tdc_pkg::B_DP] & active);
    end
  end

  // =====================================
  // Checks
  ctl_write_a: assert property (@(posedge clk) disable iff (!nrst)
    ctlWr |=> ctl == ($past(writedata[7:0]) & tdc_pkg::CTL_WMASK))
    else $error("control write not stored");
  off_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (st == tdc_pkg::S_OFF && ctl[tdc_pkg::B_CAD]) |=> !toneAEnable && !toneBEnable)
    else $error("tone active in off interval");
  read_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (read && waitrequest && idx == tdc_pkg::IDX_CTL_RD && st == tdc_pkg::S_OFF)
    |=> (readdata[7:0] & tdc_pkg::CTL_GENS) == 8'h00)
    else $error("enable bits read nonzero in off interval");
  done_set_a: assert property (@(posedge clk) disable iff (!nrst)
    onEnd |=> doneFlag ##1 (irq || doneMask))
    else $error("done flag or interrupt missing");
  irq_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    (doneMask && $past(doneMask)) |-> !irq)
    else $error("masked interrupt raised");
  repeat_a: assert property (@(posedge clk) disable iff (!nrst)
    (offEnd && !ctl[tdc_pkg::B_OS]) |=> st == tdc_pkg::S_ON && cnt == onTime)
    else $error("continuous cadence did not repeat");
  oneshot_a: assert property (@(posedge clk) disable iff (!nrst)
    (offEnd && ctl[tdc_pkg::B_OS]) |=> ctl == tdc_pkg::CTL_RST && st == tdc_pkg::S_IDLE)
    else $error("one-shot did not clear control");
  relay_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctl[tdc_pkg::B_DP] && ctl[tdc_pkg::B_CAD] && st == tdc_pkg::S_ON) |=> !generalIoPinOne)
    else $error("relay not off in on interval");
  hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (st == tdc_pkg::S_HOLD && !ctlWr) |=> st == tdc_pkg::S_HOLD)
    else $error("zero off time left hold");
  restart_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctlWr && writedata[tdc_pkg::B_CAD]) |=> st == tdc_pkg::S_ON && cnt == $past(onTime))
    else $error("control write did not restart cadence");

  // =====================================
  // Bus and register checks
  wait_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    !waitrequest |=> waitrequest)
    else $error("wait low for more than one cycle");
  wait_answer_a: assert property (@(posedge clk) disable iff (!nrst)
    (req && waitrequest) |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  rd_ctl_a: assert property (@(posedge clk) disable iff (!nrst)
    (read && waitrequest && idx == tdc_pkg::IDX_CTL_RD && st != tdc_pkg::S_OFF)
    |=> readdata[7:0] == $past(ctl))
    else $error("control read data wrong");
  read_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(read && waitrequest) |=> readdata == $past(readdata))
    else $error("read data changed without a read");
  reserved_bits_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctl & ~tdc_pkg::CTL_WMASK) == 8'h00)
    else $error("reserved control bits stored");
  cad_write_a: assert property (@(posedge clk) disable iff (!nrst)
    cadWr |=> onTime == $past(writedata[tdc_pkg::ON_LSB +: tdc_pkg::TW])
    && offTime == $past(writedata[tdc_pkg::OFF_LSB +: tdc_pkg::TW]))
    else $error("cadence times not stored");
  ctl_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    (!ctlWr && !(offEnd && ctl[tdc_pkg::B_OS])) |=> ctl == $past(ctl))
    else $error("control changed on its own");

  // Gating of the generators and the relay pin
  gate_ona_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctl[tdc_pkg::B_CAD] && ctl[tdc_pkg::B_TA] && st == tdc_pkg::S_ON) |=> toneAEnable)
    else $error("tone A off in on interval");
  gate_onb_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctl[tdc_pkg::B_CAD] && ctl[tdc_pkg::B_TB] && st == tdc_pkg::S_ON) |=> toneBEnable)
    else $error("tone B off in on interval");
  direct_a: assert property (@(posedge clk) disable iff (!nrst)
    !ctl[tdc_pkg::B_CAD] |=> toneAEnable == $past(ctl[tdc_pkg::B_TA])
    && toneBEnable == $past(ctl[tdc_pkg::B_TB]))
    else $error("tones do not follow enable bits");
  pin_direct_a: assert property (@(posedge clk) disable iff (!nrst)
    !ctl[tdc_pkg::B_CAD] |=> generalIoPinOne == !$past(ctl[tdc_pkg::B_DP]))
    else $error("pin one does not follow dial enable");
  dp_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctl[tdc_pkg::B_CAD] && st == tdc_pkg::S_OFF) |=> generalIoPinOne)
    else $error("relay dropped in off interval");
  hold_enable_a: assert property (@(posedge clk) disable iff (!nrst)
    (st == tdc_pkg::S_HOLD && ctl[tdc_pkg::B_TA]) |=> toneAEnable)
    else $error("tone A off while held");

  // Done flag and interrupt
  done_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (doneFlag && !statWr) |=> doneFlag)
    else $error("done flag lost");
  done_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (statWr && writedata[tdc_pkg::B_DONE] && !onEnd) |=> !doneFlag)
    else $error("done flag not cleared");
  irq_unmask_a: assert property (@(posedge clk) disable iff (!nrst)
    (doneFlag && !doneMask) |=> irq)
    else $error("unmasked interrupt missing");
  irq_low_a: assert property (@(posedge clk) disable iff (!nrst)
    !doneFlag |=> !irq)
    else $error("interrupt without done flag");
  mask_write_a: assert property (@(posedge clk) disable iff (!nrst)
    maskWr |=> doneMask == $past(writedata[tdc_pkg::B_DONE]))
    else $error("mask not stored");
  oneshot_irq_a: assert property (@(posedge clk) disable iff (!nrst)
    (onEnd && ctl[tdc_pkg::B_OS] && !doneMask && !maskWr) |-> ##2 irq)
    else $error("one-shot interrupt missing");

  // Sequencer progress
  timer_run_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctlWr && writedata[tdc_pkg::B_CAD] && (writedata[7:0] & tdc_pkg::CTL_GENS) == 8'h00)
    |=> st == tdc_pkg::S_ON)
    else $error("timer did not start without enables");
  oneshot_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (onEnd && ctl[tdc_pkg::B_OS]) |=> st == tdc_pkg::S_OFF)
    else $error("one-shot did not leave on interval");
  idle_stay_a: assert property (@(posedge clk) disable iff (!nrst)
    (st == tdc_pkg::S_IDLE && !ctlWr) |=> st == tdc_pkg::S_IDLE)
    else $error("cadence restarted on its own");
  idle_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    (ctlWr && !writedata[tdc_pkg::B_CAD]) |=> st == tdc_pkg::S_IDLE)
    else $error("cadence not stopped by write");
  cnt_step_a: assert property (@(posedge clk) disable iff (!nrst)
    (st == tdc_pkg::S_ON && tick && !lastStep && !ctlWr) |=> cnt == $past(cnt) - tdc_pkg::T_ONE)
    else $error("step count wrong");
  off_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (onEnd && (ctl[tdc_pkg::B_OS] || offTime != tdc_pkg::T_ZERO)) |=> cnt == $past(offTime))
    else $error("off time not loaded");
  hold_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (onEnd && !ctl[tdc_pkg::B_OS] && offTime == tdc_pkg::T_ZERO) |=> st == tdc_pkg::S_HOLD)
    else $error("zero off time did not hold");
endmodule : tdc_cadence_ctl
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the tone, dial-pulse and cadence control block.
  Assumes the block's Avalon-MM slave answers with one wait cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin badCount++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  // ==========================================
  // Signals and design
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, toneAEnable, toneBEnable, generalIoPinOne, irq;
  logic [31:0] rv;
  int badCount = 0;
  int testsRun = 0;
  // Short step keeps cadence intervals a few cycles long
  tdc_cadence_ctl #(.STEP_CYCLES(4)) uut (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .toneAEnable(toneAEnable), .toneBEnable(toneBEnable),
    .generalIoPinOne(generalIoPinOne), .irq(irq));
  always #20 clk = ~clk;
  // ==========================================
  // Helpers
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stopTest
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= wd;
    do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin badCount++; $display("FAIL bus expected ack seen timeout"); stopTest(); end
  endtask : bus
  task automatic rdChk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    `CHK(nm, exp, rv)
  endtask : rdChk
  task automatic waitOn(input bit useIrq, input logic v);
    int n;
    n = 0;
    while (((useIrq ? irq : toneAEnable) !== v) && n < 300) begin @(posedge clk); n++; end
    if (n >= 300) begin badCount++; $display("FAIL wait expected %0h seen timeout", v); stopTest(); end
  endtask : waitOn
  // ==========================================
  // Scenarios
  task automatic testReset();
    rdChk("ctl", tdc_pkg::IDX_CTL_RD, 32'h0);
    rdChk("cad", tdc_pkg::IDX_CAD_RD, 32'h0190_0320);
    `CHK("pin", 1'b1, generalIoPinOne)
    `CHK("toneA", 1'b0, toneAEnable)
    `CHK("irq", 1'b0, irq)
    rdChk("unmapped", 8'h10, 32'h0);
    $display("TEST reset done");
  endtask : testReset
  task automatic testDirect();
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h03);
    rdChk("ctl", tdc_pkg::IDX_CTL_RD, 32'h03);
    `CHK("toneA", 1'b1, toneAEnable)
    `CHK("toneB", 1'b1, toneBEnable)
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h01);
    repeat (2) @(posedge clk);
    `CHK("toneB", 1'b0, toneBEnable)
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h00);
    repeat (2) @(posedge clk);
    `CHK("toneA", 1'b0, toneAEnable)
    $display("TEST direct done");
  endtask : testDirect
  task automatic testContinuous();
    bus(1'b1, tdc_pkg::IDX_CAD_WR, 32'h0002_0003);
    bus(1'b1, tdc_pkg::IDX_MASK, 32'h0);
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h83);
    waitOn(1'b1, 1'b1);
    `CHK("toneA", 1'b0, toneAEnable)
    rdChk("ctl off", tdc_pkg::IDX_CTL_RD, 32'h80);
    rdChk("stat", tdc_pkg::IDX_STAT, 32'h1);
    bus(1'b1, tdc_pkg::IDX_STAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq clr", 1'b0, irq)
    waitOn(1'b0, 1'b1);
    `CHK("toneB", 1'b1, toneBEnable)
    waitOn(1'b1, 1'b1);
    // Reload times after the done event, then restart
    bus(1'b1, tdc_pkg::IDX_CAD_WR, 32'h0001_0002);
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h83);
    rdChk("cad new", tdc_pkg::IDX_CAD_RD, 32'h0001_0002);
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h00);
    bus(1'b1, tdc_pkg::IDX_STAT, 32'h1);
    $display("TEST continuous done");
  endtask : testContinuous
  task automatic testTimer();
    bus(1'b1, tdc_pkg::IDX_MASK, 32'h1);
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h80);
    repeat (30) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    rdChk("stat", tdc_pkg::IDX_STAT, 32'h1);
    bus(1'b1, tdc_pkg::IDX_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h00);
    bus(1'b1, tdc_pkg::IDX_STAT, 32'h1);
    $display("TEST timer done");
  endtask : testTimer
  task automatic testOneShot();
    `CHK("pin idle", 1'b1, generalIoPinOne)
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'hE1);
    repeat (2) @(posedge clk);
    `CHK("toneA", 1'b1, toneAEnable)
    `CHK("pin", 1'b0, generalIoPinOne)
    waitOn(1'b1, 1'b1);
    `CHK("pin end", 1'b1, generalIoPinOne)
    repeat (30) @(posedge clk);
    rdChk("ctl", tdc_pkg::IDX_CTL_RD, 32'h00);
    `CHK("toneA", 1'b0, toneAEnable)
    bus(1'b1, tdc_pkg::IDX_STAT, 32'h1);
    $display("TEST oneshot done");
  endtask : testOneShot
  task automatic testHold();
    // Zero off time must leave the tone running
    bus(1'b1, tdc_pkg::IDX_CAD_WR, 32'h0001_0000);
    rdChk("cad", tdc_pkg::IDX_CAD_RD, 32'h0001_0000);
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h81);
    repeat (40) @(posedge clk);
    `CHK("toneA hold", 1'b1, toneAEnable)
    rdChk("ctl", tdc_pkg::IDX_CTL_RD, 32'h81);
    bus(1'b1, tdc_pkg::IDX_CTL_WR, 32'h00);
    $display("TEST hold done");
  endtask : testHold
  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    testReset();
    testDirect();
    testContinuous();
    testTimer();
    testOneShot();
    testHold();
    stopTest();
  end
endmodule : tb_top
`default_nettype wire
